// ===== shared/dcc_params.svh
`ifndef DCC_PARAMS_SVH
`define DCC_PARAMS_SVH
// ****************************************************************
// Register byte offsets
// ****************************************************************
`define DCC_OFS_ENA_SET   12'h000
`define DCC_OFS_ENA_CLR   12'h004
`define DCC_OFS_BURST_SET 12'h008
`define DCC_OFS_BURST_CLR 12'h00C
`define DCC_OFS_ALT_SET   12'h010
`define DCC_OFS_ALT_CLR   12'h014
`define DCC_OFS_PRIO_SET  12'h018
`define DCC_OFS_PRIO_CLR  12'h01C
`define DCC_OFS_MASK_SET  12'h020
`define DCC_OFS_MASK_CLR  12'h024
`define DCC_OFS_SW_REQ    12'h028
`define DCC_OFS_ATTR_SEL  12'h02C
`define DCC_OFS_CHMAP0    12'h030
`define DCC_OFS_CHMAP3    12'h03C
`define DCC_OFS_CTL_BASE  12'h100
`define DCC_OFS_CTL_LAST  12'h1FC
// ****************************************************************
// Fields, codes and reset values
// ****************************************************************
`define DCC_ATTR_BURST_BIT 0
`define DCC_ATTR_ALT_BIT   1
`define DCC_ATTR_PRIO_BIT  2
`define DCC_ATTR_MASK_BIT  3
`define DCC_SW_CHAN        5'h1E
`define DCC_ARB_LOG2_MAX   4'hA
`define DCC_RST_WORD       32'h0000_0000
`define DCC_MODE_STOP      3'h0
`define DCC_MODE_BASIC     3'h1
`define DCC_MODE_AUTO      3'h2
`define DCC_MODE_PINGPONG  3'h3
`define DCC_MODE_MEM_SG    3'h4
`define DCC_MODE_PER_SG    3'h6
`define DCC_SIZE_8         2'h0
`define DCC_SIZE_16        2'h1
`define DCC_SIZE_32        2'h2
`define DCC_STEP_NONE      2'h3
`endif

// ===== shared/dcc_pkg.sv
`default_nettype none
`include "dcc_params.svh"
package dcc_pkg;
  // Transfer modes held in each control structure
  typedef enum logic [2:0] {
    XFER_MODE_STOP          = `DCC_MODE_STOP,
    XFER_MODE_BASIC         = `DCC_MODE_BASIC,
    XFER_MODE_AUTO          = `DCC_MODE_AUTO,
    XFER_MODE_DOUBLE_BUFFER = `DCC_MODE_PINGPONG,
    XFER_MODE_MEM_SG        = `DCC_MODE_MEM_SG,
    XFER_MODE_PERIPH_SG     = `DCC_MODE_PER_SG
  } dcc_mode_t;

  // Control word of one structure: count of items left, mode and steps
  typedef struct packed {
    logic [6:0]  rsvd;
    logic [10:0] count;
    logic [2:0]  mode;
    logic        tail_burst_only;
    logic [3:0]  arb_log2;
    logic [1:0]  dst_step;
    logic [1:0]  src_step;
    logic [1:0]  item_size;
  } dcc_ctl_t;

  // Engine states, one-hot
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN  = 2'b10
  } dcc_state_t;

  // One item handed to the system bus side
  typedef struct packed {
    logic [4:0] chan;
    logic [1:0] item_size;
    logic [1:0] src_step;
    logic [1:0] dst_step;
  } dcc_item_t;
endpackage
`default_nettype wire

// ===== logic/dcc_top.sv
// Contract
// (RULE1) Software selects request source per channel
// (RULE2) Burst-only channels ignore single requests
// (RULE3) Alternate attribute picks alternate control structure
// (RULE4) High-priority attribute raises channel priority
// (RULE5) Request mask ignores peripheral request line
// (RULE6) Attributes of a channel read back together
// (RULE7) Primary and alternate structures programmed separately
// (RULE8) Control word encodes item size 8/16/32
// (RULE9) Control word encodes source step or none
// (RULE10) Control word encodes destination step or none
// (RULE11) Arbitration size 1 to 1024 items
// (RULE12) Tail flag forces burst-only in scatter-gather
// (RULE13) Software keeps step not below item size
// (RULE14) Disabled channel answers no request
// (RULE15) Software enables channel before each transfer
// (RULE16) Completion clears channel enable automatically
// (RULE17) Enable state readable for polling
// (RULE18) Completion writes stopped mode into structure
// (RULE19) Mode field readable, six modes
// (RULE20) Software request starts any channel
// (RULE21) Software channel completes on own interrupt
// (RULE22) Peripheral channel completes to its peripheral
// (RULE23) 32 channels, structures indexed 0 to 63
// (RULE24) Software programs count of 1 to 1024
// (RULE25) Count decrements, reads zero when complete
// (RULE26) Ping-pong alternates primary and alternate structures
// (RULE27) Lowest channel wins, high priority first
`default_nettype none
`include "dcc_params.svh"
module dcc_top
  import dcc_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata_q,
  output logic             pready_q,
  output logic             pslverr_q,
  input  wire logic [15:0] periph_sreq,
  input  wire logic [15:0] periph_breq,
  output logic             xfer_strobe_q,
  output dcc_item_t        xfer_item_q,
  output logic      [31:0] periph_done_q,
  output logic             sw_done_irq_q
);

  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [31:0]      ena_q;
  logic [31:0]      burst_q;
  logic [31:0]      alt_q;
  logic [31:0]      prio_q;
  logic [31:0]      mask_q;
  logic [31:0]      swreq_q;
  logic [4:0]       attr_sel_q;
  logic [31:0][3:0] chmap_q;
  dcc_ctl_t         ctl_q [64];
  dcc_state_t       state_q;
  logic [4:0]       cur_ch_q;
  logic             cur_alt_q;
  logic [10:0]      arb_cnt_q;
  logic [5:0]       last_idx_q;

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  logic        wr_en;
  logic        acc;
  logic        ctl_hit;
  logic        map_hit;
  logic [5:0]  ctl_idx;
  logic [1:0]  map_idx;

  // A write lands only in the access cycle that pready closes
  assign acc     = psel && !penable;
  assign wr_en   = psel && penable && pready_q && pwrite;
  assign ctl_hit = (paddr >= `DCC_OFS_CTL_BASE) && (paddr <= `DCC_OFS_CTL_LAST);
  assign map_hit = (paddr >= `DCC_OFS_CHMAP0) && (paddr <= `DCC_OFS_CHMAP3);
  assign ctl_idx = paddr[7:2];                        // RULE23
  assign map_idx = paddr[3:2];

  function automatic logic wr_at(input logic [11:0] ofs);
    return wr_en && (paddr == ofs);
  endfunction

  // ****************************************************************
  // Engine signals
  // ****************************************************************
  logic [5:0]  cur_idx;
  dcc_ctl_t    cur;
  dcc_ctl_t    other;
  logic        run;
  logic        run_done;
  logic        arb_end;
  logic        keep_on;
  logic [10:0] cur_count;
  logic [31:0] pend;
  logic        gnt_found;
  logic [4:0]  gnt_ch;
  logic [3:0]  arb_lim;

  assign cur_idx   = {cur_alt_q, cur_ch_q};                     // RULE3
  assign cur       = ctl_q[cur_idx];
  assign other     = ctl_q[{~cur_alt_q, cur_ch_q}];
  assign cur_count = cur.count;
  assign run       = (state_q == ST_RUN);
  // A stopped or empty structure ends at once rather than hanging the engine
  assign run_done  = run && ((cur.count <= 11'h001) || (cur.mode == `DCC_MODE_STOP));
  assign arb_end   = run && (arb_cnt_q == 11'h001);
  // Ping-pong keeps the channel on while the other half still holds work
  assign keep_on   = (cur.mode == `DCC_MODE_PINGPONG) && (other.mode != `DCC_MODE_STOP);

  // Request qualification per channel
  always_comb begin
    dcc_ctl_t cs;
    logic     bonly;
    logic     hwreq;
    cs    = '0;
    bonly = 1'b0;
    hwreq = 1'b0;
    pend  = '0;
    for (int i = 0; i < 32; i++) begin
      cs    = ctl_q[{alt_q[i], 5'(i)}];
      bonly = burst_q[i]                                        // RULE2
              | (cs.tail_burst_only && ((cs.mode == `DCC_MODE_MEM_SG)
                                      || (cs.mode == `DCC_MODE_PER_SG))); // RULE12
      hwreq = !mask_q[i]                                        // RULE5
              && (periph_breq[chmap_q[i]] || (periph_sreq[chmap_q[i]] && !bonly)); // RULE1
      pend[i] = ena_q[i] && (hwreq || swreq_q[i]);              // RULE14 RULE20
    end
  end

  // Fixed priority: lowest number wins, high-priority group checked last to override
  always_comb begin
    gnt_found = 1'b0;
    gnt_ch    = 5'h00;
    for (int i = 31; i >= 0; i--) begin
      if (pend[i] && !prio_q[i]) begin                          // RULE27
        gnt_found = 1'b1;
        gnt_ch    = 5'(i);
      end
    end
    for (int i = 31; i >= 0; i--) begin
      if (pend[i] && prio_q[i]) begin                           // RULE4 RULE27
        gnt_found = 1'b1;
        gnt_ch    = 5'(i);
      end
    end
  end

  // Arbitration window in items, clamped to 1024
  always_comb begin
    arb_lim = ctl_q[{alt_q[gnt_ch], gnt_ch}].arb_log2;
    if (arb_lim > `DCC_ARB_LOG2_MAX) begin
      arb_lim = `DCC_ARB_LOG2_MAX;
    end
  end

  // ****************************************************************
  // APB answer
  // ****************************************************************
  // One wait-free access phase: ready rises in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= `DCC_RST_WORD;
    end else begin
      pready_q  <= acc;
      pslverr_q <= 1'b0;
      prdata_q  <= `DCC_RST_WORD;
      if (acc) begin
        if (ctl_hit) begin
          prdata_q <= ctl_q[ctl_idx];                           // RULE19 RULE25
        end else if (map_hit) begin
          prdata_q <= chmap_q[{map_idx, 3'h7} -: 8];
        end else begin
          case (paddr)
            `DCC_OFS_ENA_SET, `DCC_OFS_ENA_CLR:     prdata_q <= ena_q; // RULE17
            `DCC_OFS_BURST_SET, `DCC_OFS_BURST_CLR: prdata_q <= burst_q;
            `DCC_OFS_ALT_SET, `DCC_OFS_ALT_CLR:     prdata_q <= alt_q;
            `DCC_OFS_PRIO_SET, `DCC_OFS_PRIO_CLR:   prdata_q <= prio_q;
            `DCC_OFS_MASK_SET, `DCC_OFS_MASK_CLR:   prdata_q <= mask_q;
            `DCC_OFS_SW_REQ:                        prdata_q <= swreq_q;
            `DCC_OFS_ATTR_SEL: begin                            // RULE6
              prdata_q <= {20'h00000, 3'h0, attr_sel_q,
                           mask_q[attr_sel_q], prio_q[attr_sel_q],
                           alt_q[attr_sel_q], burst_q[attr_sel_q]};
            end
            default: pslverr_q <= 1'b1;
          endcase
        end
      end
    end
  end

  // ****************************************************************
  // Channel attributes and enables
  // ****************************************************************
  // Enable: software set wins over a completion clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ena_q <= `DCC_RST_WORD;
    end else begin
      logic [31:0] nxt;
      nxt = ena_q;
      if (wr_at(`DCC_OFS_ENA_CLR)) begin
        nxt = nxt & ~pwdata;
      end
      if (run_done && !keep_on) begin
        nxt[cur_ch_q] = 1'b0;                                   // RULE16
      end
      if (wr_at(`DCC_OFS_ENA_SET)) begin
        nxt = nxt | pwdata;                                     // RULE15
      end
      ena_q <= nxt;
    end
  end

  // Burst-only, priority and mask attributes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      burst_q <= `DCC_RST_WORD;
      prio_q  <= `DCC_RST_WORD;
      mask_q  <= `DCC_RST_WORD;
    end else begin
      if (wr_at(`DCC_OFS_BURST_SET)) burst_q <= burst_q | pwdata;   // RULE2
      if (wr_at(`DCC_OFS_BURST_CLR)) burst_q <= burst_q & ~pwdata;
      if (wr_at(`DCC_OFS_PRIO_SET))  prio_q  <= prio_q | pwdata;    // RULE4
      if (wr_at(`DCC_OFS_PRIO_CLR))  prio_q  <= prio_q & ~pwdata;
      if (wr_at(`DCC_OFS_MASK_SET))  mask_q  <= mask_q | pwdata;    // RULE5
      if (wr_at(`DCC_OFS_MASK_CLR))  mask_q  <= mask_q & ~pwdata;
    end
  end

  // Alternate select: ping-pong flip on completion, then software bits override it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alt_q <= `DCC_RST_WORD;
    end else begin
      logic [31:0] nxt;
      nxt = alt_q;
      if (run_done && (cur.mode == `DCC_MODE_PINGPONG)) begin
        nxt[cur_ch_q] = ~cur_alt_q;                             // RULE26
      end
      if (wr_at(`DCC_OFS_ALT_SET)) nxt = nxt | pwdata;          // RULE3
      if (wr_at(`DCC_OFS_ALT_CLR)) nxt = nxt & ~pwdata;
      alt_q <= nxt;
    end
  end

  // Software requests stay pending until taken; a new request wins over the take
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      swreq_q <= `DCC_RST_WORD;
    end else begin
      logic [31:0] nxt;
      nxt = swreq_q;
      if (state_q == ST_IDLE && gnt_found && !ctl_auto(gnt_ch)) begin
        nxt[gnt_ch] = 1'b0;
      end
      if (run_done) begin
        nxt[cur_ch_q] = 1'b0;
      end
      if (wr_at(`DCC_OFS_SW_REQ)) begin
        nxt = nxt | pwdata;                                     // RULE20
      end
      swreq_q <= nxt;
    end
  end

  // Auto mode keeps a software start alive until the whole transfer is done
  function automatic logic ctl_auto(input logic [4:0] ch);
    return ctl_q[{alt_q[ch], ch}].mode == `DCC_MODE_AUTO;
  endfunction

  // Channel map and attribute readback pointer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chmap_q    <= '0;
      attr_sel_q <= 5'h00;
    end else begin
      if (wr_en && map_hit) begin
        chmap_q[{map_idx, 3'h7} -: 8] <= pwdata;                // RULE1
      end
      if (wr_at(`DCC_OFS_ATTR_SEL)) begin
        attr_sel_q <= pwdata[4:0];
      end
    end
  end

  // ****************************************************************
  // Control structures
  // ****************************************************************
  // Engine updates first; a software write to the same word overrides it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 64; i++) begin
        ctl_q[i] <= '0;
      end
    end else begin
      if (run) begin
        ctl_q[cur_idx].count <= (cur.count == 11'h000) ? 11'h000
                                : 11'(cur.count - 11'h001);     // RULE25
        if (run_done) begin
          ctl_q[cur_idx].count <= 11'h000;
          ctl_q[cur_idx].mode  <= `DCC_MODE_STOP;               // RULE18
        end
      end
      if (wr_en && ctl_hit) begin
        ctl_q[ctl_idx] <= pwdata;                               // RULE7 RULE8 RULE9 RULE10
      end
    end
  end

  // ****************************************************************
  // Transfer engine
  // ****************************************************************
  // Window ends at the arbitration size or on completion, then re-arbitrate
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q   <= ST_IDLE;
      cur_ch_q  <= 5'h00;
      cur_alt_q <= 1'b0;
      arb_cnt_q <= 11'h001;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (gnt_found) begin
            state_q   <= ST_RUN;
            cur_ch_q  <= gnt_ch;
            cur_alt_q <= alt_q[gnt_ch];
            arb_cnt_q <= 11'h001 << arb_lim;                    // RULE11
          end
        end
        ST_RUN: begin
          arb_cnt_q <= 11'(arb_cnt_q - 11'h001);
          if (run_done || arb_end) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Item strobes and completion pulses toward bus and peripherals
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xfer_strobe_q <= 1'b0;
      xfer_item_q   <= '0;
      periph_done_q <= `DCC_RST_WORD;
      sw_done_irq_q <= 1'b0;
      last_idx_q    <= 6'h00;
    end else begin
      xfer_strobe_q         <= run && (cur.mode != `DCC_MODE_STOP);
      xfer_item_q.chan      <= cur_ch_q;
      xfer_item_q.item_size <= cur.item_size;                   // RULE8
      xfer_item_q.src_step  <= cur.src_step;                    // RULE9
      xfer_item_q.dst_step  <= cur.dst_step;                    // RULE10
      last_idx_q            <= cur_idx;
      periph_done_q         <= `DCC_RST_WORD;
      sw_done_irq_q         <= run_done && (cur_ch_q == `DCC_SW_CHAN); // RULE21
      if (run_done && (cur_ch_q != `DCC_SW_CHAN)) begin
        periph_done_q[cur_ch_q] <= 1'b1;                        // RULE22
      end
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  AST_PREADY_NEXT: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable |=> pready_q ##1 !pready_q)
    else $error("pready missing after setup");
  AST_DISABLED_IDLE: assert property (@(posedge pclk) disable iff (!presetn) // RULE14
    $rose(run) |-> $past(ena_q[gnt_ch]))
    else $error("disabled channel started");
  AST_AUTO_OFF: assert property (@(posedge pclk) disable iff (!presetn) // RULE16
    run_done && !keep_on && !wr_at(`DCC_OFS_ENA_SET) |=> !ena_q[last_idx_q[4:0]])
    else $error("enable not cleared on completion");
  AST_STOP_MODE: assert property (@(posedge pclk) disable iff (!presetn) // RULE18
    run_done && !(wr_en && ctl_hit) |=> ctl_q[last_idx_q].mode == `DCC_MODE_STOP
                                        && ctl_q[last_idx_q].count == 11'h000)
    else $error("mode not stopped on completion");
  AST_COUNT_DOWN: assert property (@(posedge pclk) disable iff (!presetn) // RULE25
    run && !run_done && !(wr_en && ctl_hit)
    |=> ctl_q[last_idx_q].count == 11'($past(cur_count) - 11'h001))
    else $error("count did not step down");
  AST_SW_IRQ: assert property (@(posedge pclk) disable iff (!presetn) // RULE21
    run_done && cur_ch_q == `DCC_SW_CHAN |=> sw_done_irq_q && periph_done_q == 32'h0)
    else $error("software channel completion lost");
  AST_PERIPH_DONE: assert property (@(posedge pclk) disable iff (!presetn) // RULE22
    run_done && cur_ch_q != `DCC_SW_CHAN |=> periph_done_q[last_idx_q[4:0]] && !sw_done_irq_q)
    else $error("peripheral completion lost");
  AST_PRIO_WIN: assert property (@(posedge pclk) disable iff (!presetn) // RULE27
    state_q == ST_IDLE && |(pend & prio_q) |=> run && prio_q[cur_ch_q])
    else $error("normal channel beat high priority");
  AST_MASK_HOLD: assert property (@(posedge pclk) disable iff (!presetn) // RULE5
    state_q == ST_IDLE && gnt_found && mask_q[gnt_ch] |-> swreq_q[gnt_ch])
    else $error("masked peripheral request served");
  AST_BURST_ONLY: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
    state_q == ST_IDLE && gnt_found && burst_q[gnt_ch] && !swreq_q[gnt_ch]
    |-> periph_breq[chmap_q[gnt_ch]])
    else $error("single request served on burst-only channel");

endmodule
`default_nettype wire

// ===== dv/dcc_periph_model.sv
`default_nettype none
module dcc_periph_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        go,
  input  wire logic        burst,
  input  wire logic [3:0]  src,
  input  wire logic [4:0]  chan,
  input  wire logic [31:0] periph_done_q,
  output logic      [15:0] periph_sreq,
  output logic      [15:0] periph_breq
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Peripheral request source
  // ****************************************
  logic served_q;
  // Request holds until the channel reports completion, as a data level would
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) served_q <= 1'b0;
    else if (!go) served_q <= 1'b0;
    else if (periph_done_q[chan]) served_q <= 1'b1;
  end
  // Lines not requesting sit at their inactive low level
  always_comb begin
    periph_sreq = 16'h0000;
    periph_breq = 16'h0000;
    periph_sreq[src] = go && !burst && !served_q;
    periph_breq[src] = go && burst && !served_q;
  end
endmodule
`default_nettype wire

// ===== dv/tb_dma_channel_control.sv
`default_nettype none
`include "dcc_params.svh"
`define CHK(nm, ex, gt) begin checked++; if ((gt) !== (ex)) begin bad_count++; \
  $display("[ERR] %s exp %0h got %0h", nm, ex, gt); end end
module tb_dma_channel_control
  import dcc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Signals and monitor state
  // ****************************************
  logic        pclk = 1'b0;
  logic        presetn, psel, penable, pwrite, go, burst, e;
  logic        pready_q, pslverr_q, xfer_strobe_q, sw_done_irq_q;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata_q, periph_done_q, v, w, r, seed = 32'h4938_6A35;
  logic [31:0] done_acc = 32'h0000_0000;
  logic [15:0] periph_sreq, periph_breq;
  logic [10:0] n;
  logic [4:0]  ch, first_ch;
  logic [1:0]  sz;
  dcc_item_t   xfer_item_q, last_item;
  dcc_mode_t   md;
  int          bad_count = 0, checked = 0, n_stb = 0, n_irq = 0;

  dcc_top i_dcc_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata_q,
    .pready_q, .pslverr_q, .periph_sreq, .periph_breq, .xfer_strobe_q, .xfer_item_q,
    .periph_done_q, .sw_done_irq_q);
  dcc_periph_model i_dcc_periph_model (.pclk, .presetn, .go, .burst, .src(4'h5),
    .chan(5'h03), .periph_done_q, .periph_sreq, .periph_breq);

  always #12.5 pclk = ~pclk;
  // Count items and completions; cleared between scenarios off the edge
  always @(posedge pclk) begin
    if (xfer_strobe_q === 1'b1) begin
      n_stb++;
      last_item = xfer_item_q;
      if (n_stb == 1) first_ch = xfer_item_q.chan;
    end
    if (sw_done_irq_q === 1'b1) n_irq++;
    done_acc = done_acc | periph_done_q;
  end
  // ****************************************
  // Tasks and functions
  // ****************************************
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  // 32-bit items, fixed source, word destination, widest arbitration window
  function automatic logic [31:0] mkw(dcc_mode_t m, logic [10:0] c);
    return {7'h00, c, m, 1'b0, 4'hA, 2'h2, 2'h3, 2'h2};
  endfunction
  function automatic logic [11:0] ca(logic [5:0] i);
    return 12'(`DCC_OFS_CTL_BASE + 4 * i);
  endfunction
  // One transfer; the wait is bounded since the slave latency is not assumed
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready_q !== 1'b1 && k < 50);
    v = prdata_q;
    e = pslverr_q;
    psel <= 1'b0;
    penable <= 1'b0;
    `CHK("pready", 1'b1, pready_q)
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0000_0000);
  endtask
  task automatic clr_mon();
    @(negedge pclk);
    n_stb = 0;
    n_irq = 0;
    done_acc = 32'h0000_0000;
  endtask
  // Software polls the enables until every channel in m has stopped
  task automatic wait_off(input logic [31:0] m);
    int k;
    k = 0;
    do begin
      rd(`DCC_OFS_ENA_SET);
      k++;
    end while ((v & m) != 32'h0000_0000 && k < 100);
    `CHK("enable_off", 32'h0000_0000, v & m)
  endtask
  task automatic quiet();
    repeat (20) @(posedge pclk);
    `CHK("no_items", 0, n_stb)
  endtask
  task automatic test_done();
    if (bad_count == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    #500000;
    bad_count++;
    test_done();
  end

  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, go, burst} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values and an unmapped address
    rd(`DCC_OFS_ENA_SET);
    `CHK("ena_rst", 32'h0000_0000, v)
    rd(12'h040);
    `CHK("unmapped_err", 1'b1, e)
    // Each attribute set, read back together, cleared
    for (int k = 0; k < 4; k++) begin
      ch = 5'(rnd());
      wr(12'(`DCC_OFS_BURST_SET + 8 * k), 32'h0000_0001 << ch);
      wr(`DCC_OFS_ATTR_SEL, {27'h0000000, ch});
      rd(`DCC_OFS_ATTR_SEL);
      `CHK("attr", {23'h000000, ch, 4'(1 << k)}, v)
      wr(12'(`DCC_OFS_BURST_CLR + 8 * k), 32'h0000_0001 << ch);
      rd(`DCC_OFS_ATTR_SEL);
      `CHK("attr_clr", {23'h000000, ch, 4'h0}, v)
    end
    // Every mode, random legal fields, primary and alternate kept apart
    md = md.first();
    repeat (6) begin
      r = rnd();
      sz = 2'(r[1:0] % 3);
      w = {r[31:25], 11'(r[24:15]) + 11'h001, md, r[10], (r[9:6] > 10) ? 4'hA : r[9:6],
           2'h3 - 2'(r[5:4] % (4 - sz)), 2'h3 - 2'(r[3:2] % (4 - sz)), sz};
      wr(ca({1'b0, r[20:16]}), w);
      wr(ca({1'b1, r[20:16]}), w ^ 32'hFE00_0000);
      rd(ca({1'b0, r[20:16]}));
      `CHK("ctl_pri", w, v)
      rd(ca({1'b1, r[20:16]}));
      `CHK("ctl_alt", w ^ 32'hFE00_0000, v)
      md = md.next();
    end
    // Software-started transfer on the dedicated channel
    n = 11'(rnd() % 13 + 3);
    w = mkw(XFER_MODE_AUTO, n);
    wr(ca({1'b0, `DCC_SW_CHAN}), w);
    wr(`DCC_OFS_ENA_SET, 32'h4000_0000);
    clr_mon();
    wr(`DCC_OFS_SW_REQ, 32'h4000_0000);
    wait_off(32'h4000_0000);
    `CHK("sw_items", 32'(n), n_stb)
    `CHK("sw_item", {5'h1E, 2'h2, 2'h3, 2'h2}, last_item)
    `CHK("sw_irq", 1, n_irq)
    `CHK("sw_periph", 32'h0000_0000, done_acc)
    rd(ca({1'b0, `DCC_SW_CHAN}));
    `CHK("sw_ctl", w & 32'hFE00_07FF, v)
    // Channel 3 fed by source 5, held off by disable, mask and burst-only in turn
    wr(`DCC_OFS_CHMAP0, 32'h0000_5000);
    w = mkw(XFER_MODE_BASIC, n);
    wr(ca(6'h03), w);
    clr_mon();
    go <= 1'b1;
    quiet();
    wr(`DCC_OFS_MASK_SET, 32'h0000_0008);
    wr(`DCC_OFS_ENA_SET, 32'h0000_0008);
    quiet();
    wr(`DCC_OFS_BURST_SET, 32'h0000_0008);
    wr(`DCC_OFS_MASK_CLR, 32'h0000_0008);
    quiet();
    burst <= 1'b1;
    wait_off(32'h0000_0008);
    `CHK("per_items", 32'(n), n_stb)
    `CHK("per_chan", 5'h03, last_item.chan)
    `CHK("per_done", 32'h0000_0008, done_acc)
    `CHK("per_irq", 0, n_irq)
    go <= 1'b0;
    wr(`DCC_OFS_BURST_CLR, 32'h0000_0008);
    // Two simultaneous requests, with and without a high-priority channel
    w = mkw(XFER_MODE_AUTO, 11'h002);
    for (int p = 0; p < 2; p++) begin
      wr(p ? `DCC_OFS_PRIO_CLR : `DCC_OFS_PRIO_SET, 32'h0000_0020);
      wr(ca(6'h02), w);
      wr(ca(6'h05), w);
      wr(`DCC_OFS_ENA_SET, 32'h0000_0024);
      clr_mon();
      wr(`DCC_OFS_SW_REQ, 32'h0000_0024);
      wait_off(32'h0000_0024);
      `CHK("first_chan", p ? 5'h02 : 5'h05, first_ch)
      `CHK("pair_items", 4, n_stb)
      `CHK("pair_done", 32'h0000_0024, done_acc)
    end
    // Ping-pong: the primary half ends, the channel stays on and flips to alternate
    wr(ca(6'h07), mkw(XFER_MODE_DOUBLE_BUFFER, 11'h002));
    wr(ca(6'h27), mkw(XFER_MODE_BASIC, 11'h003));
    wr(`DCC_OFS_ENA_SET, 32'h0000_0080);
    clr_mon();
    wr(`DCC_OFS_SW_REQ, 32'h0000_0080);
    repeat (8) @(posedge pclk);
    rd(`DCC_OFS_ALT_SET);
    `CHK("pp_alt", 32'h0000_0080, v)
    rd(`DCC_OFS_ENA_SET);
    `CHK("pp_ena", 32'h0000_0080, v)
    wr(`DCC_OFS_SW_REQ, 32'h0000_0080);
    wait_off(32'h0000_0080);
    `CHK("pp_items", 5, n_stb)
    test_done();
  end
endmodule
`default_nettype wire
